// file: hw/hwcfg_pkg.sv
// Package for the hardware configuration register block.
package hwcfg_pkg;
	localparam logic [7:0] HWCFG_OFFSET     = 8'h74;
	localparam logic [7:0] SOFT_RESET_STAT  = 8'h80;
	localparam int         PORT_ORDER_BIT   = 29;
	localparam int         DIRECT_ORDER_BIT = 28;
	localparam int         STRAP_BIT        = 24;
	localparam int         REQ_ONE_BIT      = 20;
	localparam int         TXALLOC_LSB      = 16;
	localparam int         TIMEOUT_BIT      = 1;
	localparam int         SOFT_RESET_REQUEST_BIT         = 0;
	localparam logic [3:0] TXALLOC_RESET    = 4'h5;
	localparam logic [3:0] TXALLOC_MIN      = 4'h2;
	localparam logic [3:0] TXALLOC_MAX      = 4'he;
	localparam logic [14:0] BUFFER_BYTES    = 15'h4000;
	localparam logic [14:0] TX_STATUS_BYTES = 15'h0200;
	localparam logic [14:0] KB_BYTES        = 15'h0400;
	localparam int         SOFT_RESET_REQUEST_TIMEOUT_US  = 100;
	localparam int         CLK_MHZ          = 10;
	localparam int         SOFT_RESET_REQUEST_TIMEOUT_CYC = SOFT_RESET_REQUEST_TIMEOUT_US * CLK_MHZ;
	localparam int         SOFT_RESET_REQUEST_HOLD_CYC    = 4;

	typedef struct packed {
		logic [14:0] tx_status_bytes;
		logic [14:0] tx_data_bytes;
		logic [14:0] rx_status_bytes;
		logic [14:0] rx_data_bytes;
	} hwcfg_split_t;

	typedef enum logic [1:0] {
		HWCFG_IDLE = 2'b00,
		HWCFG_WAIT = 2'b01,
		HWCFG_HOLD = 2'b11
	} hwcfg_state_t;
endpackage

// file: hw/hwcfg_top.sv
// Hardware configuration register with soft reset sequencer.
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Behaviour
// R1: Host halts transmitter and receiver before writing this register.
// R2: Bit 29 picks port access byte order; one means big endian.
// R3: Bit 28 picks direct-select access byte order; one means big endian.
// R4: Bit 24 reads the sampled crossover strap; writes ignored.
// R5: Host must write one to bit 20, reset value zero.
// R6: Bits 19..16 give transmit allocation in kilobytes, reset 5.
// R7: Transmit allocation stays between 2KB and 14KB.
// R8: 512 bytes of transmit allocation hold status; rest holds data.
// R9: Receive side gets the 16KB buffer minus transmit allocation.
// R10: Soft reset without running link clocks times out, setting bit 1.
// R11: After timeout host fixes the link then retries soft reset.
// R12: Writing one to bit 0 starts a self-clearing soft reset.
// R13: Soft reset clears latched transmit and receive error flags.
// R14: Byte order bits survive soft reset; hardware reset clears them.
// R15: Host requests soft reset only with the link fully awake.
// R16: Writes are ignored until a first read after reset.
// R17: Host programs transmit allocation only with codes 2 to 14.
// R18: Receive status takes one sixteenth of receive allocation.
// R19: Reserved bits read zero and ignore writes.
// R20: Timeout flag stays set until next soft reset or hardware reset.
module hwcfg_top #(
	parameter int TIMEOUT_CYC = hwcfg_pkg::SOFT_RESET_REQUEST_TIMEOUT_CYC
) (
	input  wire logic                     CLK,
	input  wire logic                     RESET,
	input  wire logic [7:0]               AVS_ADDRESS,
	input  wire logic                     AVS_READ,
	input  wire logic                     AVS_WRITE,
	input  wire logic [31:0]              AVS_WRITEDATA,
	input  wire logic [3:0]               AVS_BYTEENABLE,
	output logic      [31:0]              AVS_READDATA,
	output logic                          AVS_WAITREQUEST,
	input  wire logic                     CROSSOVER_STRAP,
	input  wire logic                     LINK_RX_CLK_OK,
	input  wire logic                     LINK_TX_CLK_OK,
	input  wire logic                     TX_ERROR_SET,
	input  wire logic                     RX_ERROR_SET,
	input  wire logic                     POWER_SAVE_EXIT,
	output logic                          PORT_BIG_ENDIAN,
	output logic                          DIRECT_BIG_ENDIAN,
	output logic                          DEVICE_ENABLE,
	output hwcfg_pkg::hwcfg_split_t       BUFFER_SPLIT,
	output logic                          SOFT_RESET_PULSE,
	output logic                          SOFT_RESET_BUSY,
	output logic                          TX_ERROR,
	output logic                          RX_ERROR
);

	logic [1:0]  strap_sync_r;
	logic [1:0]  rxok_sync_r;
	logic [1:0]  txok_sync_r;
	logic        strap_r;
	logic        port_order_r;
	logic        direct_order_r;
	logic        req_one_r;
	logic [3:0]  txalloc_r;
	logic        timeout_r;
	logic        read_seen_r;
	logic        ack_r;
	logic [15:0] count_r;
	logic        sreset_r;
	hwcfg_pkg::hwcfg_state_t state_r;
	hwcfg_pkg::hwcfg_state_t state_nxt;
	logic        access;
	logic        commit;
	logic        hit_cfg;
	logic        wr_cfg;
	logic        soft_reset_request_start;
	logic        link_ok;
	logic [31:0] cfg_word;
	logic [31:0] rdata_nxt;
	logic [3:0]  txalloc_nxt;

	// Clamp a code into the legal transmit allocation range.
	function automatic logic [3:0] clamp_alloc(input logic [3:0] code);
		if (code < hwcfg_pkg::TXALLOC_MIN)
			return hwcfg_pkg::TXALLOC_MIN;
		else if (code > hwcfg_pkg::TXALLOC_MAX)
			return hwcfg_pkg::TXALLOC_MAX;
		else
			return code;
	endfunction

	// Total transmit allocation in bytes for a size code.
	function automatic logic [14:0] alloc_bytes(input logic [3:0] code);
		return 15'(code * hwcfg_pkg::KB_BYTES);
	endfunction

	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			strap_sync_r <= 2'h0;
			rxok_sync_r  <= 2'h0;
			txok_sync_r  <= 2'h0;
		end
		else
		begin
			strap_sync_r <= {strap_sync_r[0], CROSSOVER_STRAP};
			rxok_sync_r  <= {rxok_sync_r[0], LINK_RX_CLK_OK};
			txok_sync_r  <= {txok_sync_r[0], LINK_TX_CLK_OK};
		end
	end

	assign link_ok = rxok_sync_r[1] & txok_sync_r[1];

	// One wait state per access: waitrequest drops for a single edge.
	assign access = (AVS_READ | AVS_WRITE) & ~ack_r;
	assign hit_cfg = (AVS_ADDRESS == hwcfg_pkg::HWCFG_OFFSET);
	// Writes land at the edge where the master sees waitrequest low, so a
	// stalled bus never shows a register that has already moved.
	assign commit = (AVS_READ | AVS_WRITE) & ack_r;
	// R16: writes gated
	assign wr_cfg = commit & AVS_WRITE & hit_cfg & read_seen_r;
	// R12: soft reset start
	assign soft_reset_request_start = wr_cfg & AVS_BYTEENABLE[0]
		& AVS_WRITEDATA[hwcfg_pkg::SOFT_RESET_REQUEST_BIT]
		& (state_r == hwcfg_pkg::HWCFG_IDLE);

	always_ff @(posedge CLK)
	begin
		if (RESET)
			ack_r <= 1'b0;
		else
			ack_r <= access;
	end

	always_ff @(posedge CLK)
	begin
		if (RESET)
			read_seen_r <= 1'b0;
		// R16: power save exit
		else if (POWER_SAVE_EXIT)
			read_seen_r <= 1'b0;
		else if (access & AVS_READ)
			read_seen_r <= 1'b1;
	end

	// R4: strap captured
	always_ff @(posedge CLK)
	begin
		if (RESET)
			strap_r <= 1'b0;
		else
			strap_r <= strap_sync_r[1];
	end

	// R14: hardware reset only
	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			port_order_r   <= 1'b0;
			direct_order_r <= 1'b0;
		end
		else if (wr_cfg & AVS_BYTEENABLE[3])
		begin
			// R2: port order
			port_order_r   <= AVS_WRITEDATA[hwcfg_pkg::PORT_ORDER_BIT];
			// R3: direct order
			direct_order_r <= AVS_WRITEDATA[hwcfg_pkg::DIRECT_ORDER_BIT];
		end
	end

	always_comb
	begin
		txalloc_nxt = txalloc_r;
		if (wr_cfg & AVS_BYTEENABLE[2])
			// R7: allocation clamp
			txalloc_nxt = clamp_alloc(
				AVS_WRITEDATA[hwcfg_pkg::TXALLOC_LSB +: 4]);
	end

	always_ff @(posedge CLK)
	begin
		if (RESET | sreset_r)
		begin
			req_one_r <= 1'b0;
			// R6: allocation reset
			txalloc_r <= hwcfg_pkg::TXALLOC_RESET;
		end
		else
		begin
			txalloc_r <= txalloc_nxt;
			if (wr_cfg & AVS_BYTEENABLE[2])
				req_one_r <= AVS_WRITEDATA[hwcfg_pkg::REQ_ONE_BIT];
		end
	end

	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			hwcfg_pkg::HWCFG_IDLE:
				if (soft_reset_request_start)
					state_nxt = hwcfg_pkg::HWCFG_WAIT;
			hwcfg_pkg::HWCFG_WAIT:
				if (link_ok)
					state_nxt = hwcfg_pkg::HWCFG_HOLD;
				else if (count_r == 16'(TIMEOUT_CYC - 1))
					state_nxt = hwcfg_pkg::HWCFG_IDLE;
			hwcfg_pkg::HWCFG_HOLD:
				if (count_r == 16'(hwcfg_pkg::SOFT_RESET_REQUEST_HOLD_CYC - 1))
					state_nxt = hwcfg_pkg::HWCFG_IDLE;
			default:
				state_nxt = hwcfg_pkg::HWCFG_IDLE;
		endcase
	end

	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			state_r <= hwcfg_pkg::HWCFG_IDLE;
			count_r <= 16'h0000;
		end
		else
		begin
			state_r <= state_nxt;
			if (state_nxt != state_r)
				count_r <= 16'h0000;
			else
				count_r <= count_r + 16'h0001;
		end
	end

	// The internal reset is held high for every cycle of the hold phase.
	always_ff @(posedge CLK)
	begin
		if (RESET)
			sreset_r <= 1'b0;
		else
			sreset_r <= (state_nxt == hwcfg_pkg::HWCFG_HOLD);
	end

	always_ff @(posedge CLK)
	begin
		if (RESET)
			timeout_r <= 1'b0;
		// R10: timeout sets flag
		else if (state_r == hwcfg_pkg::HWCFG_WAIT && !link_ok &&
			count_r == 16'(TIMEOUT_CYC - 1))
			timeout_r <= 1'b1;
		// R20: cleared by new request
		else if (soft_reset_request_start)
			timeout_r <= 1'b0;
	end

	// R13: errors cleared by soft reset, but a new event wins.
	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			TX_ERROR <= 1'b0;
			RX_ERROR <= 1'b0;
		end
		else
		begin
			TX_ERROR <= TX_ERROR_SET | (TX_ERROR & ~sreset_r);
			RX_ERROR <= RX_ERROR_SET | (RX_ERROR & ~sreset_r);
		end
	end

	// R19: reserved bits zero
	always_comb
	begin
		cfg_word = 32'h0000_0000;
		cfg_word[hwcfg_pkg::PORT_ORDER_BIT]   = port_order_r;
		cfg_word[hwcfg_pkg::DIRECT_ORDER_BIT] = direct_order_r;
		cfg_word[hwcfg_pkg::STRAP_BIT]        = strap_r;
		cfg_word[hwcfg_pkg::REQ_ONE_BIT]      = req_one_r;
		cfg_word[hwcfg_pkg::TXALLOC_LSB +: 4] = txalloc_r;
		cfg_word[hwcfg_pkg::TIMEOUT_BIT]      = timeout_r;
		// R12: self-clearing bit
		cfg_word[hwcfg_pkg::SOFT_RESET_REQUEST_BIT] =
			(state_r != hwcfg_pkg::HWCFG_IDLE);
		rdata_nxt = 32'h0000_0000;
		if (hit_cfg)
			rdata_nxt = cfg_word;
		else if (AVS_ADDRESS == hwcfg_pkg::SOFT_RESET_STAT)
			rdata_nxt = {30'h0, link_ok, sreset_r};
	end

	always_ff @(posedge CLK)
	begin
		if (RESET)
			AVS_READDATA <= 32'h0000_0000;
		else if (access & AVS_READ)
			AVS_READDATA <= rdata_nxt;
	end

	// Waitrequest idles high so a new request always sees one wait state.
	always_ff @(posedge CLK)
	begin
		if (RESET)
			AVS_WAITREQUEST <= 1'b1;
		else
			AVS_WAITREQUEST <= ~access;
	end

	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			PORT_BIG_ENDIAN   <= 1'b0;
			DIRECT_BIG_ENDIAN <= 1'b0;
			DEVICE_ENABLE     <= 1'b0;
			SOFT_RESET_PULSE  <= 1'b0;
			SOFT_RESET_BUSY   <= 1'b0;
		end
		else
		begin
			PORT_BIG_ENDIAN   <= port_order_r;
			DIRECT_BIG_ENDIAN <= direct_order_r;
			DEVICE_ENABLE     <= req_one_r;
			SOFT_RESET_PULSE  <= sreset_r;
			SOFT_RESET_BUSY   <= (state_r != hwcfg_pkg::HWCFG_IDLE);
		end
	end

	always_ff @(posedge CLK)
	begin
		if (RESET)
			BUFFER_SPLIT <= '0;
		else
		begin
			// R8: transmit status share
			BUFFER_SPLIT.tx_status_bytes <= hwcfg_pkg::TX_STATUS_BYTES;
			BUFFER_SPLIT.tx_data_bytes <= alloc_bytes(txalloc_r)
				- hwcfg_pkg::TX_STATUS_BYTES;
			// R9: receive remainder
			// R18: one sixteenth status
			BUFFER_SPLIT.rx_status_bytes <= (hwcfg_pkg::BUFFER_BYTES
				- alloc_bytes(txalloc_r)) >> 4;
			BUFFER_SPLIT.rx_data_bytes <= (hwcfg_pkg::BUFFER_BYTES
				- alloc_bytes(txalloc_r))
				- ((hwcfg_pkg::BUFFER_BYTES
				- alloc_bytes(txalloc_r)) >> 4);
		end
	end

endmodule // hwcfg_top

// file: testbench/hwcfg_checker.sv
// Checker for bus timing, soft reset sequence and buffer split.
`timescale 1ns/1ps
module hwcfg_checker #(
	parameter int TIMEOUT_CYC = 20
) (
	input logic                    CLK,
	input logic                    RESET,
	input logic                    AVS_READ,
	input logic                    AVS_WRITE,
	input logic                    AVS_WAITREQUEST,
	input logic                    TX_ERROR_SET,
	input logic                    PORT_BIG_ENDIAN,
	input logic                    DIRECT_BIG_ENDIAN,
	input logic                    DEVICE_ENABLE,
	input hwcfg_pkg::hwcfg_split_t BUFFER_SPLIT,
	input logic                    SOFT_RESET_PULSE,
	input logic                    SOFT_RESET_BUSY,
	input logic                    TX_ERROR
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	logic [10:0] busy_cnt_r;
	logic [15:0] tx_all;
	logic [15:0] rx_all;
	assign tx_all = BUFFER_SPLIT.tx_status_bytes + BUFFER_SPLIT.tx_data_bytes;
	assign rx_all = BUFFER_SPLIT.rx_status_bytes + BUFFER_SPLIT.rx_data_bytes;
	always_ff @(posedge CLK)
		busy_cnt_r <= (RESET || !SOFT_RESET_BUSY) ? 11'h0 : busy_cnt_r + 11'h1;
	sequence s_taken;
		(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
	endsequence
	sequence s_hold;
		SOFT_RESET_PULSE [*4] ##1 !SOFT_RESET_PULSE;
	endsequence
	AST_ANSWER: assert property (s_taken |=> !AVS_WAITREQUEST)
		else $error("access not answered after one wait cycle");
	AST_ONE_LOW: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("waitrequest low longer than one cycle");
	AST_IDLE_HIGH: assert property (!(AVS_READ || AVS_WRITE) |=> AVS_WAITREQUEST)
		else $error("waitrequest low without a request");
	AST_HOLD_LEN: assert property ($rose(SOFT_RESET_PULSE) |-> s_hold)
		else $error("soft reset pulse not four cycles");
	AST_ORDER_KEPT: assert property (SOFT_RESET_PULSE |=>
		$stable(PORT_BIG_ENDIAN) && $stable(DIRECT_BIG_ENDIAN))
		else $error("byte order changed by soft reset");
	AST_SPLIT: assert property (!$past(RESET) && !$past(RESET, 2) &&
		!$past(RESET, 3) |-> BUFFER_SPLIT.tx_status_bytes == 15'h0200 &&
		tx_all >= 16'h0800 && tx_all <= 16'h3800 &&
		tx_all + rx_all == 16'h4000 &&
		{BUFFER_SPLIT.rx_status_bytes, 4'h0} == rx_all)
		else $error("buffer split inconsistent");
	AST_BUSY_BOUND: assert property (busy_cnt_r <= TIMEOUT_CYC + 16)
		else $error("soft reset sequencer never gave up");
	AST_ENABLE_CLR: assert property ($fell(SOFT_RESET_PULSE) |-> !DEVICE_ENABLE)
		else $error("required one bit survived soft reset");
	AST_ERR_CAUSE: assert property ($rose(TX_ERROR) |-> $past(TX_ERROR_SET))
		else $error("transmit error latched without cause");
endmodule // hwcfg_checker
bind hwcfg_top hwcfg_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) hwcfg_checker_i (
	.CLK(CLK), .RESET(RESET), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
	.AVS_WAITREQUEST(AVS_WAITREQUEST), .TX_ERROR_SET(TX_ERROR_SET),
	.PORT_BIG_ENDIAN(PORT_BIG_ENDIAN), .DIRECT_BIG_ENDIAN(DIRECT_BIG_ENDIAN),
	.DEVICE_ENABLE(DEVICE_ENABLE), .BUFFER_SPLIT(BUFFER_SPLIT),
	.SOFT_RESET_PULSE(SOFT_RESET_PULSE), .SOFT_RESET_BUSY(SOFT_RESET_BUSY),
	.TX_ERROR(TX_ERROR));

// file: testbench/hwcfg_host.sv
// Host model that masters the register port.
`timescale 1ns/1ps
module hwcfg_host (
	input logic         clk,
	input logic         waitrequest,
	input logic  [31:0] readdata,
	output logic [7:0]  address,
	output logic        read,
	output logic        write,
	output logic [31:0] writedata,
	output logic [3:0]  byteenable
);
	initial
	begin
		address <= 8'h0;
		read <= 1'b0;
		write <= 1'b0;
		writedata <= 32'h0;
		byteenable <= 4'hf;
	end
	// Data is inverted once released so stale values cannot pass as fresh.
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		address <= a;
		read <= !w;
		write <= w;
		writedata <= d;
		do
			@(posedge clk);
		while (waitrequest);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		writedata <= ~d;
		@(posedge clk);
	endtask
endmodule // hwcfg_host

// file: testbench/tb_hw_config_soft_reset_fifo_split.sv
// Self-checking bench for the configuration register block.
`timescale 1ns/1ps
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin \
	fail_count++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module tb_hw_config_soft_reset_fifo_split;
	logic                    clk, reset, strap, rx_ok, tx_ok, tx_set, rx_set;
	logic                    pse, rd_r, wr_r, wait_r, pbe, dbe, den, srp;
	logic                    busy, transmit_error_flag, receive_error_flag;
	logic [7:0]              addr;
	logic [31:0]             wd, rdata, q;
	logic [3:0]              be;
	hwcfg_pkg::hwcfg_split_t split;
	int                      fail_count, samples_checked, cyc, c;
	hwcfg_host hwcfg_host_i (.clk(clk), .waitrequest(wait_r),
		.readdata(rdata), .address(addr), .read(rd_r), .write(wr_r),
		.writedata(wd), .byteenable(be));
	hwcfg_top #(.TIMEOUT_CYC(20)) hwcfg_top_i (.CLK(clk), .RESET(reset),
		.AVS_ADDRESS(addr), .AVS_READ(rd_r), .AVS_WRITE(wr_r),
		.AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
		.AVS_WAITREQUEST(wait_r), .CROSSOVER_STRAP(strap),
		.LINK_RX_CLK_OK(rx_ok), .LINK_TX_CLK_OK(tx_ok),
		.TX_ERROR_SET(tx_set), .RX_ERROR_SET(rx_set), .POWER_SAVE_EXIT(pse),
		.PORT_BIG_ENDIAN(pbe), .DIRECT_BIG_ENDIAN(dbe), .DEVICE_ENABLE(den),
		.BUFFER_SPLIT(split), .SOFT_RESET_PULSE(srp),
		.SOFT_RESET_BUSY(busy), .TX_ERROR(transmit_error_flag), .RX_ERROR(receive_error_flag));
	function automatic hwcfg_pkg::hwcfg_split_t sp(input int a);
		int r;
		r = 16384 - a * 1024;
		return '{15'(512), 15'(a * 1024 - 512), 15'(r / 16), 15'(r - r / 16)};
	endfunction
	task close_out;
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task rd(input logic [7:0] a);
		hwcfg_host_i.xfer(1'b0, a, 32'h0, q);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		hwcfg_host_i.xfer(1'b1, a, d, q);
	endtask
	task idle;
		@(posedge clk);
		while (busy !== 1'b0)
			@(posedge clk);
	endtask
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			close_out();
		end
	end
	initial
	begin
		{reset, strap, rx_ok, tx_ok} <= 4'hf;
		{tx_set, rx_set, pse} <= 3'h0;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		wr(8'h74, 32'h3011_0000);
		rd(8'h74);
		`CHK("cfg", 32'h0105_0000, q)
		`CHK("split", sp(5), split)
		strap <= 1'b0;
		for (int a = 0; a < 16; a++)
		begin
			c = a < 2 ? 2 : (a > 14 ? 14 : a);
			wr(8'h74, 32'hfff0_fffe | (32'(a) << 16));
			rd(8'h74);
			`CHK("cfg", 32'h3010_0000 | (32'(c) << 16), q)
			`CHK("split", sp(c), split)
		end
		`CHK("order", 3'b111, {pbe, dbe, den})
		{tx_set, rx_set} <= 2'b11;
		@(posedge clk);
		{tx_set, rx_set} <= 2'b00;
		@(posedge clk);
		`CHK("err", 2'b11, {transmit_error_flag, receive_error_flag})
		wr(8'h74, 32'h3018_0001);
		rd(8'h74);
		`CHK("busy", 1'b1, q[0])
		idle();
		rd(8'h74);
		`CHK("soft_reset_request", 32'h3005_0000, q)
		`CHK("err", 2'b00, {transmit_error_flag, receive_error_flag})
		// Let the dead link reach the sequencer before asking for a reset.
		rx_ok <= 1'b0;
		repeat (2) @(posedge clk);
		wr(8'h74, 32'h3010_0001);
		idle();
		rd(8'h74);
		`CHK("tmo", 32'h3012_0002, q)
		rx_ok <= 1'b1;
		wr(8'h74, 32'h3010_0001);
		idle();
		rd(8'h74);
		`CHK("retry", 32'h3005_0000, q)
		rd(8'h80);
		`CHK("status", 32'h0000_0002, q)
		rd(8'h40);
		`CHK("unmapped", 32'h0, q)
		pse <= 1'b1;
		@(posedge clk);
		pse <= 1'b0;
		wr(8'h74, 32'h0010_0000);
		rd(8'h74);
		`CHK("locked", 32'h3005_0000, q)
		reset <= 1'b1;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		rd(8'h74);
		`CHK("hwrst", 32'h0005_0000, q)
		close_out();
	end
endmodule // tb_hw_config_soft_reset_fifo_split
